/* File: rtl/tmrtsk_params.svh */
// offsets, field positions, reset values and widths of the timer task block
`ifndef TMRTSK_PARAMS_SVH
`define TMRTSK_PARAMS_SVH

// task registers, write-only strobes
`define TMRTSK_OFS_START_TASK      12'h000
`define TMRTSK_OFS_STOP_TASK       12'h004
`define TMRTSK_OFS_INCREMENT_TASK  12'h008
`define TMRTSK_OFS_CLEAR_TASK      12'h00C
`define TMRTSK_OFS_SHUTDOWN_TASK   12'h010
`define TMRTSK_OFS_CAPTURE_TASK    12'h040

// subscription registers
`define TMRTSK_OFS_START_SUB       12'h080
`define TMRTSK_OFS_STOP_SUB        12'h084
`define TMRTSK_OFS_INCREMENT_SUB   12'h088
`define TMRTSK_OFS_CLEAR_SUB       12'h08C
`define TMRTSK_OFS_SHUTDOWN_SUB    12'h090
`define TMRTSK_OFS_CAPTURE_SUB     12'h0C0

// mode and capture/compare value registers
`define TMRTSK_OFS_MODE            12'h504
`define TMRTSK_OFS_CC              12'h540

// stride between the entries of a register array
`define TMRTSK_STRIDE              12'h004

// field layout
`define TMRTSK_TRIGGER_BIT         0
`define TMRTSK_CHANNEL_INDEX_LSB           0
`define TMRTSK_CHANNEL_INDEX_MSB           3
`define TMRTSK_SUB_EN_BIT          31
`define TMRTSK_MODE_BIT            0

// reset values
`define TMRTSK_RST_SUB             32'h0000_0000
`define TMRTSK_RST_MODE            1'b0
`define TMRTSK_RST_CC              32'h0000_0000
`define TMRTSK_RST_COUNT           32'h0000_0000

// sizes
`define TMRTSK_NUM_CHANNELS        16
`define TMRTSK_NUM_CC              6
`define TMRTSK_NUM_PLAIN_SUBS      5

`endif

/* File: rtl/tmrtsk_pkg.sv */
// types shared by the timer task block
`default_nettype none
package tmrtsk_pkg;

   // timer operating mode
   typedef enum logic
   {
      TMRTSK_MODE_TIMER   = 1'b0,
      TMRTSK_MODE_COUNTER = 1'b1
   } tmrtsk_mode_e;

   // index of each subscription slot
   typedef enum logic [3:0]
   {
      TMRTSK_SUB_START     = 4'h0,
      TMRTSK_SUB_STOP      = 4'h1,
      TMRTSK_SUB_INCREMENT = 4'h2,
      TMRTSK_SUB_CLEAR     = 4'h3,
      TMRTSK_SUB_SHUTDOWN  = 4'h4,
      TMRTSK_SUB_CAPTURE0  = 4'h5
   } tmrtsk_sub_e;

   typedef logic [3:0] tmrtsk_chan_t;

endpackage : tmrtsk_pkg

`default_nettype wire

/* File: rtl/tmrtsk_subscriber.sv */
// one subscription register: channel index, enable, and the task trigger it yields
`timescale 1ns/1ps
`default_nettype none
`include "tmrtsk_params.svh"

module tmrtsk_subscriber
   import tmrtsk_pkg::*;
#(
   parameter int NUM_CHANNELS = `TMRTSK_NUM_CHANNELS
)
(
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic                    wr_en,
   input  wire logic [31:0]             wr_data,
   input  wire logic [3:0]              byte_en,
   input  wire logic [NUM_CHANNELS-1:0] channel_events,
   output logic      [31:0]             cfg_rd,
   output logic                         trigger
);

   tmrtsk_chan_t channel_index_r;
   logic         enable_r;

   ////////////////////////////////////////////////////////////////////////////
   // channel index lives in byte lane 0, enable in lane 3
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         channel_index_r <= tmrtsk_chan_t'(`TMRTSK_RST_SUB);
         enable_r        <= 1'b0;
      end
      else if (wr_en)
      begin
         if (byte_en[0])
            channel_index_r <= wr_data[`TMRTSK_CHANNEL_INDEX_MSB:`TMRTSK_CHANNEL_INDEX_LSB];
         if (byte_en[3])
            enable_r <= wr_data[`TMRTSK_SUB_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // readback, unused bits as zero
   always_comb
   begin
      cfg_rd = 32'h0000_0000;
      cfg_rd[`TMRTSK_CHANNEL_INDEX_MSB:`TMRTSK_CHANNEL_INDEX_LSB] = channel_index_r;
      cfg_rd[`TMRTSK_SUB_EN_BIT] = enable_r;
   end

   // channels are one-cycle pulses on this clock, so the trigger is a pulse too
   assign trigger = enable_r && channel_events[channel_index_r];

endmodule : tmrtsk_subscriber

`default_nettype wire

/* File: rtl/tmrtsk_top.sv */
// timer task strobes, event subscriptions, counter core and capture registers
//
// What this block does
// - increment task write advances the counter by one, only in counter mode.
// - capture task n write copies the timer value into capture register n.
// - start subscription holds channel index and enable; channel event starts timer.
// - stop subscription holds channel index and enable; channel event stops timer.
// - clear subscription holds channel index and enable; channel event zeroes timer.
// - increment subscription lets a channel event advance the counter in counter mode.
// - shutdown subscription holds channel index and enable; channel event shuts timer.
// - start and stop in the same clock: stop wins, start ignored.
// - clear and capture in the same clock: clear wins, capture register gets zero.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tmrtsk_params.svh"

module tmrtsk_top
   import tmrtsk_pkg::*;
#(
   parameter int COUNT_WIDTH  = 32,
   parameter int NUM_CC       = `TMRTSK_NUM_CC,
   parameter int NUM_CHANNELS = `TMRTSK_NUM_CHANNELS
)
(
   input  wire logic                    CLK,
   input  wire logic                    NRST,
   input  wire logic [11:0]             AVS_ADDRESS,
   input  wire logic                    AVS_READ,
   input  wire logic                    AVS_WRITE,
   input  wire logic [31:0]             AVS_WRITEDATA,
   input  wire logic [3:0]              AVS_BYTEENABLE,
   output logic      [31:0]             AVS_READDATA,
   output logic                         AVS_WAITREQUEST,
   input  wire logic [NUM_CHANNELS-1:0] EVT_CHANNELS,
   output logic      [COUNT_WIDTH-1:0]  TIMER_VALUE,
   output logic                         TIMER_RUNNING
);

   localparam int NUM_SUBS = `TMRTSK_NUM_PLAIN_SUBS + NUM_CC;

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   logic                   ack_r;
   logic                   wr_go;
   logic                   trig_lane;
   logic [31:0]            readdata_r;
   logic [31:0]            readdata_nxt;
   tmrtsk_mode_e           mode_r;
   logic                   running_r;
   logic [COUNT_WIDTH-1:0] count_r;
   logic [COUNT_WIDTH-1:0] cc_r [NUM_CC];

   // one subscription slot per task, capture slots last
   logic [NUM_SUBS-1:0]    sub_wr;
   logic [NUM_SUBS-1:0]    sub_trig;
   logic [31:0]            sub_rd [NUM_SUBS];

   // software strobes, one cycle wide
   logic                   sw_start;
   logic                   sw_stop;
   logic                   sw_increment;
   logic                   sw_clear;
   logic                   sw_shutdown;
   logic [NUM_CC-1:0]      sw_capture;
   logic [NUM_CC-1:0]      cc_wr;
   logic                   mode_wr;

   // merged triggers as the task logic sees them
   logic                   start_hit;
   logic                   stop_hit;
   logic                   increment_hit;
   logic                   clear_hit;
   logic [NUM_CC-1:0]      capture_hit;

   ////////////////////////////////////////////////////////////////////////////
   // avalon slave handshake: one wait state, then the request is accepted

   // waitrequest drops in the cycle after the request is seen
   assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_r;

   // ack clears itself after one cycle, so back-to-back requests
   // each get their own wait state and none is taken twice
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= (AVS_READ || AVS_WRITE) && !ack_r;
      end
   end

   // a write takes effect only at the edge where waitrequest is low
   assign wr_go     = AVS_WRITE && ack_r;
   // task triggers live in bit 0, so lane 0 must be enabled;
   // a write with lane 0 off leaves every task untouched
   assign trig_lane = AVS_BYTEENABLE[0] && AVS_WRITEDATA[`TMRTSK_TRIGGER_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // software task strobes; a zero in the trigger bit is no trigger at all
   // the strobes last one cycle, so nothing is left to read back

   assign sw_start     = wr_go && trig_lane
                         && (AVS_ADDRESS == `TMRTSK_OFS_START_TASK);
   assign sw_stop      = wr_go && trig_lane
                         && (AVS_ADDRESS == `TMRTSK_OFS_STOP_TASK);
   assign sw_increment = wr_go && trig_lane
                         && (AVS_ADDRESS == `TMRTSK_OFS_INCREMENT_TASK);
   assign sw_clear     = wr_go && trig_lane
                         && (AVS_ADDRESS == `TMRTSK_OFS_CLEAR_TASK);
   assign sw_shutdown  = wr_go && trig_lane
                         && (AVS_ADDRESS == `TMRTSK_OFS_SHUTDOWN_TASK);
   assign mode_wr      = wr_go && AVS_BYTEENABLE[0]
                         && (AVS_ADDRESS == `TMRTSK_OFS_MODE);

   // capture strobes and capture register writes, one per entry
   // a software write of a capture register needs all four lanes
   always_comb
   begin
      for (int n = 0; n < NUM_CC; n++)
      begin
         sw_capture[n] = wr_go && trig_lane
                         && (AVS_ADDRESS == 12'(`TMRTSK_OFS_CAPTURE_TASK
                                              + n * `TMRTSK_STRIDE));
         cc_wr[n]      = wr_go && (AVS_BYTEENABLE == 4'hF)
                         && (AVS_ADDRESS == 12'(`TMRTSK_OFS_CC + n * `TMRTSK_STRIDE));
      end
   end

   // subscription register selects: five plain slots, then the capture slots
   // byte lanes are sorted out inside each subscription register
   always_comb
   begin
      for (int i = 0; i < NUM_SUBS; i++)
      begin
         if (i < `TMRTSK_NUM_PLAIN_SUBS)
         begin
            sub_wr[i] = wr_go
                        && (AVS_ADDRESS == 12'(`TMRTSK_OFS_START_SUB
                                             + i * `TMRTSK_STRIDE));
         end
         else
         begin
            sub_wr[i] = wr_go
                        && (AVS_ADDRESS == 12'(`TMRTSK_OFS_CAPTURE_SUB
                            + (i - `TMRTSK_NUM_PLAIN_SUBS) * `TMRTSK_STRIDE));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // subscription registers, each picks one channel of the event interconnect
   // a trigger is a plain and of enable and channel, so it adds no latency

   for (genvar g = 0; g < NUM_SUBS; g++)
   begin : g_sub
      tmrtsk_subscriber #(
         .NUM_CHANNELS (NUM_CHANNELS)
      ) u_sub (
         .clk            (CLK),
         .nrst           (NRST),
         .wr_en          (sub_wr[g]),
         .wr_data        (AVS_WRITEDATA),
         .byte_en        (AVS_BYTEENABLE),
         .channel_events (EVT_CHANNELS),
         .cfg_rd         (sub_rd[g]),
         .trigger        (sub_trig[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // merge software and channel triggers of each task
   // a software and a channel trigger in one cycle count as one task

   assign start_hit     = sw_start || sub_trig[TMRTSK_SUB_START];
   // the deprecated shutdown halts the timer exactly as stop does
   assign stop_hit      = sw_stop || sub_trig[TMRTSK_SUB_STOP]
                          || sw_shutdown || sub_trig[TMRTSK_SUB_SHUTDOWN];
   assign increment_hit = sw_increment || sub_trig[TMRTSK_SUB_INCREMENT];
   assign clear_hit     = sw_clear || sub_trig[TMRTSK_SUB_CLEAR];
   assign capture_hit   = sw_capture
                          | sub_trig[NUM_SUBS-1:`TMRTSK_NUM_PLAIN_SUBS];

   ////////////////////////////////////////////////////////////////////////////
   // mode register: timer or counter
   // a mode change keeps the count; software clears it if it must

   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         mode_r <= tmrtsk_mode_e'(`TMRTSK_RST_MODE);
      end
      else if (mode_wr)
      begin
         mode_r <= tmrtsk_mode_e'(AVS_WRITEDATA[`TMRTSK_MODE_BIT]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // run state; stop checked first so a same-cycle start is dropped
   // the run flag only gates timer mode; counter mode ignores it

   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         running_r <= 1'b0;
      end
      else if (stop_hit)
      begin
         running_r <= 1'b0;
      end
      else if (start_hit)
      begin
         running_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter core; clear beats any increment in the same cycle
   // no prescaler here: timer mode advances once per clock, and the
   // count wraps silently at its full width

   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         count_r <= COUNT_WIDTH'(`TMRTSK_RST_COUNT);
      end
      else if (clear_hit)
      begin
         count_r <= '0;
      end
      else if (mode_r == TMRTSK_MODE_TIMER)
      begin
         // timer mode ticks every clock while running; increment is ignored
         if (running_r)
         begin
            count_r <= count_r + COUNT_WIDTH'(1);
         end
      end
      else if (increment_hit)
      begin
         count_r <= count_r + COUNT_WIDTH'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // capture registers; a clear in the same cycle forces the captured value to zero
   // a capture takes the count as it stood before this edge's tick
   // a capture outranks a software write of the same register

   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         for (int n = 0; n < NUM_CC; n++)
         begin
            cc_r[n] <= COUNT_WIDTH'(`TMRTSK_RST_CC);
         end
      end
      else
      begin
         for (int n = 0; n < NUM_CC; n++)
         begin
            if (capture_hit[n] && clear_hit)
            begin
               cc_r[n] <= '0;
            end
            else if (capture_hit[n])
            begin
               cc_r[n] <= count_r;
            end
            else if (cc_wr[n])
            begin
               cc_r[n] <= AVS_WRITEDATA[COUNT_WIDTH-1:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux; task registers and unmapped offsets read zero
   // write-only task offsets simply fall through to the zero default

   always_comb
   begin
      readdata_nxt = 32'h0000_0000;
      for (int i = 0; i < NUM_SUBS; i++)
      begin
         if (i < `TMRTSK_NUM_PLAIN_SUBS)
         begin
            if (AVS_ADDRESS == 12'(`TMRTSK_OFS_START_SUB + i * `TMRTSK_STRIDE))
            begin
               readdata_nxt = sub_rd[i];
            end
         end
         else if (AVS_ADDRESS == 12'(`TMRTSK_OFS_CAPTURE_SUB
                                    + (i - `TMRTSK_NUM_PLAIN_SUBS) * `TMRTSK_STRIDE))
         begin
            readdata_nxt = sub_rd[i];
         end
      end
      for (int n = 0; n < NUM_CC; n++)
      begin
         if (AVS_ADDRESS == 12'(`TMRTSK_OFS_CC + n * `TMRTSK_STRIDE))
         begin
            readdata_nxt = 32'(cc_r[n]);
         end
      end
      if (AVS_ADDRESS == `TMRTSK_OFS_MODE)
      begin
         readdata_nxt = {31'h0000_0000, mode_r};
      end
   end

   // sample read data in the wait cycle so it stands when waitrequest drops
   // a capture landing in that same cycle shows up only on the next read
   always_ff @(posedge CLK)
   begin
      if (!NRST)
      begin
         readdata_r <= 32'h0000_0000;
      end
      else if (AVS_READ && !ack_r)
      begin
         readdata_r <= readdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   // every data output comes straight from a register

   assign AVS_READDATA  = readdata_r;
   assign TIMER_VALUE   = count_r;
   assign TIMER_RUNNING = running_r;

endmodule : tmrtsk_top

`default_nettype wire

/* File: testbench/tmrtsk_top_chk.sv */
// port-level assertions for the timer task block
`timescale 1ns/1ps
`default_nettype none
module tmrtsk_chk
#(
   parameter int COUNT_WIDTH  = 32,
   parameter int NUM_CHANNELS = 16
)
(
   input wire logic                    CLK,
   input wire logic                    NRST,
   input wire logic [11:0]             AVS_ADDRESS,
   input wire logic                    AVS_READ,
   input wire logic                    AVS_WRITE,
   input wire logic [31:0]             AVS_WRITEDATA,
   input wire logic [3:0]              AVS_BYTEENABLE,
   input wire logic [31:0]             AVS_READDATA,
   input wire logic                    AVS_WAITREQUEST,
   input wire logic [NUM_CHANNELS-1:0] EVT_CHANNELS,
   input wire logic [COUNT_WIDTH-1:0]  TIMER_VALUE,
   input wire logic                    TIMER_RUNNING
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   logic acc;
   logic hit;
   logic mode_r;
   // accepted writes; a channel event in the same cycle would blur the outcome
   assign acc = AVS_WRITE && !AVS_WAITREQUEST && EVT_CHANNELS == '0;
   assign hit = acc && AVS_BYTEENABLE[0] && AVS_WRITEDATA[0];
   // shadow of the mode bit, the increment task depends on it
   always_ff @(posedge CLK)
   begin
      if (!NRST)
         mode_r <= 1'b0;
      else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 12'h504 && AVS_BYTEENABLE[0])
         mode_r <= AVS_WRITEDATA[0];
   end
////////////////////////////////////////
   sequence s_req;
      $rose(AVS_READ || AVS_WRITE);
   endsequence
   sequence s_one_wait;
      AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
   endsequence
   property p_wait;
      s_req |-> s_one_wait;
   endproperty
   a_wait: assert property (p_wait) else $error("wait state not one cycle");
   property p_start;
      hit && AVS_ADDRESS == 12'h000 |=> TIMER_RUNNING;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_stop;
      hit && AVS_ADDRESS == 12'h004 |=> !TIMER_RUNNING;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not taken");
   property p_clear;
      hit && AVS_ADDRESS == 12'h00C |=> TIMER_VALUE == '0;
   endproperty
   a_clear: assert property (p_clear) else $error("clear not taken");
   property p_shut;
      hit && AVS_ADDRESS == 12'h010 |=> !TIMER_RUNNING;
   endproperty
   a_shut: assert property (p_shut) else $error("shutdown not taken");
   property p_inc_cnt;
      hit && AVS_ADDRESS == 12'h008 && mode_r
         |=> TIMER_VALUE == COUNT_WIDTH'($past(TIMER_VALUE) + 1);
   endproperty
   a_inc_cnt: assert property (p_inc_cnt) else $error("count step wrong");
   property p_inc_tmr;
      hit && AVS_ADDRESS == 12'h008 && !mode_r && !TIMER_RUNNING |=> $stable(TIMER_VALUE);
   endproperty
   a_inc_tmr: assert property (p_inc_tmr) else $error("timer mode counted");
   property p_zero_wr;
      acc && AVS_WRITEDATA == '0 && AVS_ADDRESS < 12'h058 && !TIMER_RUNNING
         |=> $stable(TIMER_VALUE) && !TIMER_RUNNING;
   endproperty
   a_zero_wr: assert property (p_zero_wr) else $error("zero write acted");
   property p_task_rd;
      AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS < 12'h058 |-> AVS_READDATA == '0;
   endproperty
   a_task_rd: assert property (p_task_rd) else $error("task read not zero");
endmodule : tmrtsk_chk

bind tmrtsk_top tmrtsk_chk #(.COUNT_WIDTH(COUNT_WIDTH), .NUM_CHANNELS(NUM_CHANNELS)) i_chk
(
   .CLK(CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .EVT_CHANNELS(EVT_CHANNELS), .TIMER_VALUE(TIMER_VALUE), .TIMER_RUNNING(TIMER_RUNNING)
);
`default_nettype wire

/* File: testbench/tmrtsk_evt_src.sv */
// event interconnect model: one-cycle pulses on the channel lines
`timescale 1ns/1ps
`default_nettype none
module tmrtsk_evt_src
#(
   parameter int NUM_CHANNELS = 16
)
(
   input  wire logic                    clk,
   output var  logic [NUM_CHANNELS-1:0] evt
);
   // idle channels stay low, a held level would retrigger every cycle
   initial evt = '0;
   // pulse after gap idle cycles, so slow sources can be modelled too
   task automatic fire(input logic [NUM_CHANNELS-1:0] mask, input int gap);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      evt <= mask;
      @(posedge clk);
      evt <= '0;
   endtask : fire
endmodule : tmrtsk_evt_src
`default_nettype wire

/* File: testbench/tmrtsk_top_tb.sv */
// self-checking bench for the timer task block
`timescale 1ns/1ps
`default_nettype none
module tmrtsk_top_tb
   import tmrtsk_pkg::*;
;
   logic        clk;
   logic        nrst;
   logic [11:0] avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic [15:0] evt;
   logic [31:0] timer_value;
   logic        timer_running;
   logic [31:0] rd_data;
   int          err_total;
   int          tests_run;
   tmrtsk_top i_dut
   (
      .CLK(clk), .NRST(nrst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
      .EVT_CHANNELS(evt), .TIMER_VALUE(timer_value), .TIMER_RUNNING(timer_running)
   );
   tmrtsk_evt_src i_evt
   (
      .clk(clk),
      .evt(evt)
   );
////////////////////////////////////////
   // value compare, counted and reported at once
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // flag compare
   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chk1
   // one bus cycle, held until waitrequest is low at a rising edge
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do
         @(posedge clk);
      while (avs_waitrequest);
      // the answer is taken at the very edge where waitrequest is seen low
      rd_data = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask : bus
   // one channel pulse, then look once its effect has landed
   task automatic ev(input logic [15:0] m);
      i_evt.fire(m, 1);
      @(negedge clk);
   endtask : ev
   // subscriptions: reset zero, hold channel and enable; task slots read zero
   task automatic t_regs;
      for (int i = 0; i < 5; i++)
      begin
         bus(1'b0, 12'(12'h080 + 4 * i), 32'h0);
         chk(rd_data, 32'h0);
         bus(1'b1, 12'(12'h080 + 4 * i), 32'h8000_0001 + i);
         bus(1'b0, 12'(12'h080 + 4 * i), 32'h0);
         chk(rd_data, 32'h8000_0001 + i);
      end
      bus(1'b1, 12'h0C0, 32'h8000_0004);
      for (int a = 0; a < 12'h058; a += 4)
      begin
         bus(1'b0, 12'(a), 32'h0);
         chk(rd_data, 32'h0);
      end
   endtask : t_regs
   // software tasks in timer mode, zero writes, captures of a stopped timer
   task automatic t_sw;
      logic [31:0] v;
      bus(1'b1, 12'h000, 32'h0);
      @(negedge clk);
      chk1(timer_running, 1'b0);
      bus(1'b1, 12'h000, 32'h1);
      bus(1'b1, 12'h004, 32'h0);
      @(negedge clk);
      chk1(timer_running, 1'b1);
      bus(1'b1, 12'h004, 32'h1);
      @(negedge clk);
      v = timer_value;
      chk1(v != 32'h0, 1'b1);
      bus(1'b1, 12'h008, 32'h1);
      @(negedge clk);
      chk(timer_value, v);
      bus(1'b1, 12'h000, 32'h1);
      bus(1'b1, 12'h010, 32'h1);
      @(negedge clk);
      chk1(timer_running, 1'b0);
      v = timer_value;
      bus(1'b1, 12'h544, 32'h0000_5A5A);
      bus(1'b0, 12'h544, 32'h0);
      chk(rd_data, 32'h0000_5A5A);
      for (int n = 0; n < 6; n++)
      begin
         bus(1'b1, 12'(12'h040 + 4 * n), 32'h1);
         bus(1'b0, 12'(12'h540 + 4 * n), 32'h0);
         chk(rd_data, v);
      end
   endtask : t_sw
   // counter mode: software and channel increments
   task automatic t_cnt;
      bus(1'b1, 12'h504, {31'h0, TMRTSK_MODE_COUNTER});
      bus(1'b0, 12'h504, 32'h0);
      chk(rd_data, 32'h1);
      bus(1'b1, 12'h00C, 32'h1);
      bus(1'b1, 12'h008, 32'h1);
      bus(1'b1, 12'h008, 32'h1);
      @(negedge clk);
      chk(timer_value, 32'h2);
      ev(16'h0008);
      chk(timer_value, 32'h3);
      bus(1'b1, 12'h504, 32'h0);
   endtask : t_cnt
   // channel tasks, same-cycle priorities, a disabled subscription
   task automatic t_chan;
      ev(16'h0002);
      chk1(timer_running, 1'b1);
      ev(16'h0004);
      chk1(timer_running, 1'b0);
      ev(16'h0002);
      ev(16'h0020);
      chk1(timer_running, 1'b0);
      ev(16'h0006);
      chk1(timer_running, 1'b0);
      ev(16'h0002);
      ev(16'h0010);
      chk(timer_value, 32'h0);
      ev(16'h0004);
      bus(1'b0, 12'h540, 32'h0);
      chk(rd_data, 32'h0);
      bus(1'b1, 12'h080, 32'h0000_0001);
      ev(16'h0002);
      chk1(timer_running, 1'b0);
   endtask : t_chan
   // verdict and end of run
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   // clock, 10 ns period
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // cut a hang short: the run needs well under 1000 cycles
   initial
   begin
      repeat (5000) @(posedge clk);
      err_total++;
      finish_test;
   end
   // reset for 16 cycles, then the scenarios
   initial
   begin
      err_total      = 0;
      tests_run      = 0;
      nrst           = 1'b0;
      avs_address    = 12'h000;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = 32'h0;
      avs_byteenable = 4'hF;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      t_regs;
      t_sw;
      t_cnt;
      t_chan;
      finish_test;
   end
endmodule : tmrtsk_top_tb
`default_nettype wire
